/* File: core/acr_pkg.sv */
package acr_pkg;

	// ****************************************************************
	// Register indices; the bus byte address is four times the index.
	// ****************************************************************
	localparam logic [7:0] IDX_INT_ENABLE       = 8'hA8;
	localparam logic [7:0] IDX_SYS_CONTROL      = 8'hC0;
	localparam logic [7:0] IDX_RESULT_HIGH      = 8'hCE;
	localparam logic [7:0] IDX_RESULT_LOW       = 8'hCF;
	localparam logic [7:0] IDX_ADC_CONTROL      = 8'hD8;
	localparam logic [7:0] IDX_INPUT_SELECT     = 8'hDA;
	localparam logic [7:0] IDX_ANALOG_PIN_LOW   = 8'hDC;
	localparam logic [7:0] IDX_ANALOG_PIN_HIGH  = 8'hDD;
	localparam logic [7:0] IDX_REFERENCE_CONFIG = 8'hDE;
	localparam logic [7:0] IDX_CMP_CONTROL      = 8'hDF;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int POS_RDY         = 0;
	localparam int POS_CLK_DIV_LO  = 6;
	localparam int POS_SHIFT_EN    = 5;
	localparam int POS_SHIFT_LO    = 6;
	localparam int POS_SRC_TOP     = 4;
	localparam int POS_POWER_ON    = 5;
	localparam int POS_IE_ADC      = 6;
	localparam int POS_IE_GLOBAL   = 7;
	localparam int POS_CMP_ON      = 0;
	localparam int POS_CMP_PIN     = 1;
	localparam int POS_CMP_LVL_LO  = 2;
	localparam int POS_BG_SWITCH   = 4;
	localparam int POS_BG_TRIM_LO  = 5;

	// ****************************************************************
	// Reset values and codes.
	// ****************************************************************
	localparam logic [7:0]  RST_BYTE         = 8'h00;
	localparam logic [7:0]  REF_EXTERNAL     = 8'h0A;
	localparam logic [7:0]  REF_VDD          = 8'h04;
	localparam logic [7:0]  REF_INTERNAL_USE = 8'h0B;
	localparam logic [7:0]  REF_LDO_OUT      = 8'h09;
	localparam logic [15:0] ADC_VECTOR_ADDR  = 16'h0033;

	// ****************************************************************
	// Converter clock divide ratios for select codes 00, 01, 10, 11.
	// ****************************************************************
	localparam logic [6:0] DIV_CODE0 = 7'd16;
	localparam logic [6:0] DIV_CODE1 = 7'd32;
	localparam logic [6:0] DIV_CODE2 = 7'd64;
	localparam logic [6:0] DIV_CODE3 = 7'd8;

	typedef struct packed
	{
		logic ext_ref;
		logic vdd_ref;
		logic int_ref_use;
		logic pin_drive_2v1;
	} acr_ref_type;

	typedef enum logic [1:0]
	{
		ST_IDLE    = 2'b00,
		ST_CONVERT = 2'b01
	} acr_state_type;

endpackage

/* File: core/acr_top.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Set the ready flag when a conversion finishes.
// - Hardware clears the ready flag when the CPU takes the converter vector.
// - Control bits 7:6 divide the oscillator by 16, 32, 64 or 8.
// - Without shifting the high result byte shows the top result bits.
// - With shifting the high byte shifts by one to four places.
// - Source field picks one of sixteen pins or the internal 1.2 V reference.
// - Low analog-pin register bits make port 1 pins analog.
// - High analog-pin register makes port 0 pins 0-1, port 3 pins 2-7 analog.
// - Reference code 0xA takes an external reference on port 3 pin 7.
// - Reference code 0x4 uses the supply as reference.
// - Reference code 0x0B drives internal 2.1 V on the pin and uses it.
// - Reference code 0x9 drives the 2.1 V regulator onto the pin.
// - Comparator level field selects 1.9, 2.3, 2.7 or 3.6 V.
// - Three-bit trim field tunes the converter reference.
// - Comparator output bit: write steers pin drive, read gives result.
// - Comparator runs only while its enable bit is one.
// - Converter runs only while system control bit 5 is one.
// - Ready requests an interrupt only with both enables set.
// - The converter interrupt vectors to address 0033H.
module acr_top
	import acr_pkg::*;
(
	// Clock and reset.
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// APB slave.
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Converter.
	output logic             ADC_CLK_EN,
	output logic             ADC_START,
	output logic      [4:0]  ADC_SRC,
	input  wire logic        ADC_DONE,
	input  wire logic [9:0]  ADC_DATA,
	// Pins and reference.
	output logic      [15:0] ANALOG_EN,
	output acr_ref_type      ADC_REF,
	output logic      [2:0]  BG_TRIM,
	output logic             BG_SWITCH,
	// Comparator.
	output logic             CMP_EN,
	output logic      [1:0]  CMP_LEVEL,
	output logic             CMP_PIN_DRIVE,
	input  wire logic        CMP_RESULT,
	// CPU interrupt.
	output logic             IRQ,
	output logic      [15:0] IRQ_VECTOR,
	input  wire logic        IRQ_ACK
);

	// ****************************************************************
	// Bus slave.
	// ****************************************************************
	logic [7:0] adc_control_q;
	logic [7:0] input_select_q;
	logic [7:0] pin_low_q;
	logic [7:0] pin_high_q;
	logic [7:0] ref_config_q;
	logic [7:0] cmp_control_q;
	logic [7:0] sys_control_q;
	logic [7:0] int_enable_q;
	logic [7:0] result_high_q;
	logic [7:0] result_low_q;
	logic       rdy_q;
	logic [7:0] rd_byte;
	logic       rd_hit;
	logic       wr_en;
	logic [7:0] idx;

	assign idx   = PADDR[9:2];
	assign wr_en = PSEL && PENABLE && PREADY && PWRITE && rd_hit;

	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		unique case (idx)
			IDX_INT_ENABLE:       rd_byte = int_enable_q;
			IDX_SYS_CONTROL:      rd_byte = sys_control_q;
			IDX_RESULT_HIGH:      rd_byte = result_high_q;
			IDX_RESULT_LOW:       rd_byte = result_low_q;
			IDX_ADC_CONTROL:      rd_byte = {adc_control_q[7:6], 5'h00, rdy_q};
			IDX_INPUT_SELECT:     rd_byte = input_select_q;
			IDX_ANALOG_PIN_LOW:   rd_byte = pin_low_q;
			IDX_ANALOG_PIN_HIGH:  rd_byte = pin_high_q;
			IDX_REFERENCE_CONFIG: rd_byte = ref_config_q;
			// Reading the output bit returns the live comparator result.
			IDX_CMP_CONTROL:      rd_byte = {cmp_control_q[7:2], CMP_RESULT, cmp_control_q[0]};
			default:              rd_hit  = 1'b0;
		endcase
	end

	// The answer is prepared in the setup cycle so the access phase ends at once.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !rd_hit;
			PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Software-written registers.
	// ****************************************************************
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			adc_control_q  <= RST_BYTE;
			input_select_q <= RST_BYTE;
			pin_low_q      <= RST_BYTE;
			pin_high_q     <= RST_BYTE;
			ref_config_q   <= RST_BYTE;
			cmp_control_q  <= RST_BYTE;
			sys_control_q  <= RST_BYTE;
			int_enable_q   <= RST_BYTE;
		end
		else if (wr_en)
		begin
			unique case (idx)
				IDX_ADC_CONTROL:      adc_control_q  <= {PWDATA[7:6], 6'h00};
				IDX_INPUT_SELECT:     input_select_q <= PWDATA[7:0];
				IDX_ANALOG_PIN_LOW:   pin_low_q      <= PWDATA[7:0];
				IDX_ANALOG_PIN_HIGH:  pin_high_q     <= PWDATA[7:0];
				IDX_REFERENCE_CONFIG: ref_config_q   <= PWDATA[7:0];
				IDX_CMP_CONTROL:      cmp_control_q  <= PWDATA[7:0];
				IDX_SYS_CONTROL:      sys_control_q  <= PWDATA[7:0];
				IDX_INT_ENABLE:       int_enable_q   <= PWDATA[7:0];
				default:              ;
			endcase
		end
	end

	// ****************************************************************
	// Converter clock divider.
	// ****************************************************************
	logic [6:0] div_cnt_q;
	logic [6:0] div_reload;
	logic       power_on;

	assign power_on = sys_control_q[POS_POWER_ON];

	always_comb
	begin
		unique case (adc_control_q[POS_CLK_DIV_LO +: 2])
			2'b00:   div_reload = DIV_CODE0;
			2'b01:   div_reload = DIV_CODE1;
			2'b10:   div_reload = DIV_CODE2;
			2'b11:   div_reload = DIV_CODE3;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			div_cnt_q  <= 7'd0;
			ADC_CLK_EN <= 1'b0;
		end
		else if (!power_on)
		begin
			div_cnt_q  <= 7'd0;
			ADC_CLK_EN <= 1'b0;
		end
		else
		begin
			ADC_CLK_EN <= (div_cnt_q == 7'd0);
			div_cnt_q  <= (div_cnt_q == 7'd0) ? div_reload - 7'd1 : div_cnt_q - 7'd1;
		end
	end

	// ****************************************************************
	// Conversion sequencing and result capture.
	// ****************************************************************
	acr_state_type state_q;
	logic          capture;
	logic [13:0]   shifted;
	logic [7:0]    high_d;

	assign capture = (state_q == ST_CONVERT) && ADC_DONE && power_on;
	assign shifted = 14'({ADC_DATA, 4'h0} << input_select_q[POS_SHIFT_LO +: 2]);

	always_comb
	begin
		if (input_select_q[POS_SHIFT_EN])
			high_d = shifted[12:5];
		else
			high_d = ADC_DATA[9:2];
	end

	// A new conversion starts on a converter clock tick while powered.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_q   <= ST_IDLE;
			ADC_START <= 1'b0;
			ADC_SRC   <= 5'h00;
		end
		else
		begin
			ADC_START <= 1'b0;
			unique case (state_q)
				ST_IDLE:
					if (power_on && ADC_CLK_EN)
					begin
						state_q   <= ST_CONVERT;
						ADC_START <= 1'b1;
						ADC_SRC   <= input_select_q[POS_SRC_TOP:0];
					end
				ST_CONVERT:
					if (!power_on || ADC_DONE)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Both result bytes change in the same cycle, on capture of a finished conversion.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			result_high_q <= RST_BYTE;
			result_low_q  <= RST_BYTE;
		end
		else if (capture)
		begin
			result_high_q <= high_d;
			result_low_q  <= {ADC_DATA[1:0], 6'h00};
		end
	end

	// ****************************************************************
	// Ready flag and interrupt.
	// ****************************************************************
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			rdy_q <= 1'b0;
		else if (capture)
			rdy_q <= 1'b1;
		else if (IRQ_ACK)
			rdy_q <= 1'b0;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			IRQ        <= 1'b0;
			IRQ_VECTOR <= 16'h0000;
		end
		else
		begin
			IRQ        <= rdy_q && !IRQ_ACK && int_enable_q[POS_IE_ADC] && int_enable_q[POS_IE_GLOBAL];
			IRQ_VECTOR <= ADC_VECTOR_ADDR;
		end
	end

	// ****************************************************************
	// Pins, reference and comparator outputs.
	// ****************************************************************
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ANALOG_EN     <= 16'h0000;
			ADC_REF       <= '0;
			BG_TRIM       <= 3'h0;
			BG_SWITCH     <= 1'b0;
			CMP_EN        <= 1'b0;
			CMP_LEVEL     <= 2'h0;
			CMP_PIN_DRIVE <= 1'b0;
		end
		else
		begin
			ANALOG_EN             <= {pin_high_q, pin_low_q};
			ADC_REF.ext_ref       <= (ref_config_q == REF_EXTERNAL);
			ADC_REF.vdd_ref       <= (ref_config_q == REF_VDD);
			ADC_REF.int_ref_use   <= (ref_config_q == REF_INTERNAL_USE);
			ADC_REF.pin_drive_2v1 <= (ref_config_q == REF_INTERNAL_USE) || (ref_config_q == REF_LDO_OUT);
			BG_TRIM               <= cmp_control_q[POS_BG_TRIM_LO +: 3];
			BG_SWITCH             <= cmp_control_q[POS_BG_SWITCH];
			CMP_EN                <= cmp_control_q[POS_CMP_ON];
			CMP_LEVEL             <= cmp_control_q[POS_CMP_LVL_LO +: 2];
			CMP_PIN_DRIVE         <= cmp_control_q[POS_CMP_PIN] && cmp_control_q[POS_CMP_ON];
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	rdy_set_a: assert property (capture |=> rdy_q)
		else $error("ready flag not set after a finished conversion");
	rdy_clear_a: assert property (IRQ_ACK && !capture |=> !rdy_q)
		else $error("ready flag not cleared by vector acknowledge");
	div_eight_a: assert property (disable iff (!RST_N || !power_on) ADC_CLK_EN && adc_control_q[7:6] == 2'b11
			&& div_cnt_q == 7'd7 |=> !ADC_CLK_EN[*7] ##1 ADC_CLK_EN)
		else $error("converter clock spacing wrong for divide by eight");
	high_plain_a: assert property (capture && !input_select_q[POS_SHIFT_EN]
			|=> result_high_q == $past(ADC_DATA[9:2]) && result_low_q[7:6] == $past(ADC_DATA[1:0]))
		else $error("unshifted result bytes wrong");
	high_shift_a: assert property (capture && input_select_q[7:5] == 3'b111
			|=> result_high_q == {$past(ADC_DATA[5:0]), 2'b00})
		else $error("four bit shifted result wrong");
	start_src_a: assert property (ADC_START |-> ADC_SRC == $past(input_select_q[4:0]) && state_q == ST_CONVERT)
		else $error("conversion started with wrong source");
	pins_follow_a: assert property (##1 ANALOG_EN == $past({pin_high_q, pin_low_q}))
		else $error("analog pin enables do not follow registers");
	ref_ldo_a: assert property (ref_config_q == REF_LDO_OUT |=> ADC_REF.pin_drive_2v1 && !ADC_REF.int_ref_use)
		else $error("regulator output code decoded wrongly");
	cmp_off_a: assert property (!cmp_control_q[POS_CMP_ON] |=> !CMP_EN && !CMP_PIN_DRIVE)
		else $error("comparator active while disabled");
	power_off_a: assert property (!power_on |=> !ADC_START && !ADC_CLK_EN)
		else $error("converter active while powered down");
	irq_gate_a: assert property (!int_enable_q[POS_IE_GLOBAL] |=> !IRQ)
		else $error("interrupt raised with global enable off");
	irq_vector_a: assert property (IRQ |-> IRQ_VECTOR == 16'h0033)
		else $error("interrupt vector address wrong");

	capture_c: cover property (capture ##1 rdy_q);
	ack_c:     cover property (rdy_q ##1 IRQ_ACK ##1 !rdy_q);
	shift_c:   cover property (capture && input_select_q[POS_SHIFT_EN]);
	irq_c:     cover property (IRQ);

endmodule

`default_nettype wire

/* File: tb/acr_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Converter stand-in: answers each start after a set delay.
// ****************************************
module acr_conv_model
	import acr_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Converter side.
	input  wire logic       start,
	input  wire logic [7:0] delay,
	input  wire logic [9:0] sample,
	output logic            done,
	output logic      [9:0] data
);
	logic [7:0] cnt_q;

	// Outside the done cycle the data lines toggle, so stale data never looks valid.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 8'h00;
			done  <= 1'b0;
			data  <= 10'h000;
		end
		else
		begin
			done <= 1'b0;
			data <= ~data;
			if (start)
				cnt_q <= delay;
			else if (cnt_q != 8'h00)
			begin
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01)
				begin
					done <= 1'b1;
					data <= sample;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_adc_control_and_readout.sv */
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_and_readout
	import acr_pkg::*;
;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, clk_en, start, done;
	logic        bgsw, cmp_en, cmp_drv, cmp_res, irq, ack, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0]  src;
	logic [9:0]  ad_data, sample;
	logic [15:0] ana_en, vec;
	logic [2:0]  trim;
	logic [1:0]  cmp_lvl;
	logic [7:0]  delay, rd;
	logic [13:0] w;
	acr_ref_type ref_o;
	int          error_cnt, checks, cyc, p;
	logic [7:0]  regs [8] = '{IDX_RESULT_HIGH, IDX_RESULT_LOW, IDX_ADC_CONTROL, IDX_INPUT_SELECT,
		IDX_ANALOG_PIN_LOW, IDX_ANALOG_PIN_HIGH, IDX_REFERENCE_CONFIG, IDX_CMP_CONTROL};
	logic [7:0]  refc [5] = '{8'h0A, 8'h04, 8'h0B, 8'h09, 8'h05};
	logic [3:0]  refx [5] = '{4'b1000, 4'b0100, 4'b0011, 4'b0001, 4'b0000};
	logic [6:0]  divs [4] = '{7'd16, 7'd32, 7'd64, 7'd8};
	logic [4:0]  srcs [4] = '{5'h00, 5'h09, 5'h0F, 5'h10};

	// ****************************************
	// Design and converter stand-in.
	// ****************************************
	acr_top u_acr_top (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ADC_CLK_EN(clk_en), .ADC_START(start), .ADC_SRC(src), .ADC_DONE(done), .ADC_DATA(ad_data),
		.ANALOG_EN(ana_en), .ADC_REF(ref_o), .BG_TRIM(trim), .BG_SWITCH(bgsw), .CMP_EN(cmp_en),
		.CMP_LEVEL(cmp_lvl), .CMP_PIN_DRIVE(cmp_drv), .CMP_RESULT(cmp_res), .IRQ(irq),
		.IRQ_VECTOR(vec), .IRQ_ACK(ack));
	acr_conv_model u_acr_conv_model (.clk(clk), .rst_n(rst_n), .start(start), .delay(delay),
		.sample(sample), .done(done), .data(ad_data));

	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			$display("[ERR] t=%0t run timed out", $time);
			tally_and_finish();
		end
	end

	// ****************************************
	// Bus and check tasks.
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t mismatch got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h00_0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd  = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic experr);
		apb(1'b0, idx, 8'h00);
		chk({23'h0, err, rd}, {23'h0, experr, exp});
	endtask

	// Waits for the next converter done (sel) or clock enable pulse; p counts the extra edges.
	task automatic wait_ev(input logic sel);
		p = 0;
		@(posedge clk);
		while ((sel ? done : clk_en) !== 1'b1 && p < 600)
		begin
			@(posedge clk);
			p++;
		end
		if (p == 600)
		begin
			error_cnt++;
			$display("[ERR] t=%0t expected event never came", $time);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// Test sequence.
	// ****************************************
	initial
	begin
		{clk, rst_n, psel, penable, pwrite, ack, cyc, error_cnt, checks} = '0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		cmp_res = 1'b1;
		delay   = 8'h01;
		sample  = 10'h2D6;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rdc(regs[i], (i == 7) ? 8'h02 : 8'h00, 1'b0);
		rdc(8'h10, 8'h00, 1'b1);
		apb(1'b1, IDX_RESULT_HIGH, 8'hFF);
		rdc(IDX_RESULT_HIGH, 8'h00, 1'b0);
		apb(1'b1, IDX_ADC_CONTROL, 8'hFF);
		rdc(IDX_ADC_CONTROL, 8'hC0, 1'b0);
		apb(1'b1, IDX_ANALOG_PIN_LOW, 8'hA5);
		apb(1'b1, IDX_ANALOG_PIN_HIGH, 8'h3C);
		repeat (2) @(posedge clk);
		chk({16'h0, ana_en}, 32'h0000_3CA5);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, IDX_REFERENCE_CONFIG, refc[i]);
			repeat (2) @(posedge clk);
			chk({28'h0, ref_o}, {28'h0, refx[i]});
		end
		cmp_res <= 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, IDX_CMP_CONTROL, {4'h0, 2'(k), 2'b01});
			repeat (2) @(posedge clk);
			chk({29'h0, cmp_lvl, cmp_en}, {29'h0, 2'(k), 1'b1});
		end
		apb(1'b1, IDX_CMP_CONTROL, 8'hFF);
		repeat (2) @(posedge clk);
		chk({24'h0, trim, bgsw, cmp_lvl, cmp_drv, cmp_en}, 32'h0000_00FF);
		rdc(IDX_CMP_CONTROL, 8'hFD, 1'b0);
		apb(1'b1, IDX_CMP_CONTROL, 8'hAA);
		repeat (2) @(posedge clk);
		chk({24'h0, trim, bgsw, cmp_lvl, cmp_drv, cmp_en}, 32'h0000_00A8);
		apb(1'b1, IDX_SYS_CONTROL, 8'h20);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, IDX_ADC_CONTROL, {2'(c), 6'h00});
			repeat (2) wait_ev(1'b0);
			wait_ev(1'b0);
			chk(32'(p + 1), {25'h0, divs[c]});
		end
		apb(1'b1, IDX_INPUT_SELECT, 8'h00);
		repeat (2) wait_ev(1'b1);
		repeat (2) @(posedge clk);
		rdc(IDX_RESULT_HIGH, sample[9:2], 1'b0);
		rdc(IDX_RESULT_LOW, {sample[1:0], 6'h00}, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, IDX_INPUT_SELECT, {2'(k), 6'h20});
			repeat (2) wait_ev(1'b1);
			repeat (2) @(posedge clk);
			w = {4'h0, sample} << (k + 1);
			rdc(IDX_RESULT_HIGH, w[9:2], 1'b0);
		end
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, IDX_INPUT_SELECT, {3'h0, srcs[i]});
			repeat (2) wait_ev(1'b1);
			chk({27'h0, src}, {27'h0, srcs[i]});
		end
		delay <= 8'hC8;
		apb(1'b1, IDX_INT_ENABLE, 8'h40);
		wait_ev(1'b1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(IDX_ADC_CONTROL, 8'hC1, 1'b0);
		apb(1'b1, IDX_INT_ENABLE, 8'hC0);
		repeat (2) @(posedge clk);
		chk({15'h0, irq, vec}, 32'h0001_0033);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(IDX_ADC_CONTROL, 8'hC0, 1'b0);
		apb(1'b1, IDX_SYS_CONTROL, 8'h00);
		repeat (2) @(posedge clk);
		p = 0;
		repeat (100)
		begin
			@(posedge clk);
			if ((clk_en | start) === 1'b1)
				p++;
		end
		chk(32'(p), 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
